/* logic/mie_exec.sv */
// execution unit for moves, increment/decrement and decrement-branch loops
// Notes on behaviour
// - first operand of a move is the destination written
// - immediate source writes the literal following the marker
// - non-immediate source reads the given ram or sfr address
// - no register-to-register move; such codes are undefined here
// - no indirect-to-indirect move exists
// - only pointer registers zero and one serve as indirect pointers
// - immediate may go straight to pointed ram, up to top location
// - direct move to 80h writes the port zero latch
// - increment and decrement change their operand by exactly one
// - incrementing 255 gives 0
// - decrementing 0 gives 255
// - increment and decrement alter no status flag
// - decrement-branch decrements then branches if result nonzero
// - loop body runs as many times as the initial count, or 256 times when it starts at zero
`timescale 1ns/1ps
`include "mie_params.svh"
module mie_exec
  import mie_pkg::*;
#(
  parameter int RAM_DEPTH = 256
) (
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  input  wire logic [7:0]  prog_data_in,
  input  wire logic        prog_valid_in,
  output logic             prog_req_out,
  output logic [15:0]      prog_addr_out,
  output logic [7:0]       acc_out,
  output logic [7:0]       psw_out,
  output logic [7:0]       port_zero_latch_out,
  output logic             illegal_op_out
);
  mie_regs_t r;
  mie_regs_t next_r;
  logic [7:0] ram [RAM_DEPTH];
  logic       ram_we;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;

  // register bank sits at ram 00h..07h (bank zero); bank select not modelled
  function automatic logic [7:0] rd_ram(input logic [7:0] a);
    rd_ram = ram[a];
  endfunction

  // direct space: below 80h is ram, above it sfrs
  function automatic logic [7:0] rd_direct(input logic [7:0] a,
                                           input mie_regs_t s);
    if (a < `MIE_ADDR_PORT_ZERO) begin
      rd_direct = ram[a];
    end else if (a == `MIE_ADDR_PORT_ZERO) begin
      rd_direct = s.port_zero_latch;
    end else if (a == `MIE_ADDR_ACC) begin
      rd_direct = s.acc;
    end else if (a == `MIE_ADDR_PSW) begin
      rd_direct = s.psw;
    end else begin
      rd_direct = 8'h00;
    end
  endfunction

  // operand-byte count beyond the opcode
  function automatic logic [1:0] extra_bytes(input logic [7:0] op);
    extra_bytes = 2'd0;
    if (op == `MIE_OPC_MOV_DIR_IMM || op == `MIE_OPC_MOV_DIR_DIR ||
        op == `MIE_OPC_DECREMENT_BRANCH_NONZERO_OP_DIR) begin
      extra_bytes = 2'd2;
    end else if (op == `MIE_OPC_MOV_A_IMM || op == `MIE_OPC_MOV_A_DIR ||
                 op == `MIE_OPC_MOV_DIR_A || op == `MIE_OPC_INC_DIR ||
                 op == `MIE_OPC_DEC_DIR || op[7:3] == `MIE_OPC_DECREMENT_BRANCH_NONZERO_OP_RN) begin
      extra_bytes = 2'd1;
    end else if (op[3] == 1'b1 && (op[7:4] == `MIE_OPC_MOV_RI_IMM ||
                 op[7:4] == `MIE_OPC_MOV_DIR_RI ||
                 op[7:4] == `MIE_OPC_MOV_RI_DIR)) begin
      extra_bytes = 2'd1;
    end else if (op[3:1] == 3'b011 && (op[7:4] == `MIE_OPC_MOV_RI_IMM ||
                 op[7:4] == `MIE_OPC_MOV_DIR_RI ||
                 op[7:4] == `MIE_OPC_MOV_RI_DIR)) begin
      extra_bytes = 2'd1;
    end
  endfunction

  always_comb begin
    logic [7:0] op;
    logic [7:0] src;
    logic [7:0] res;
    logic [7:0] ptr;
    logic [7:0] daddr;
    logic       wr_direct;
    logic       wr_ind;
    logic       wr_reg;
    logic [15:0] seq_pc;
    logic [7:0] rel;
    next_r    = r;
    ram_we    = 1'b0;
    ram_waddr = 8'h00;
    ram_wdata = 8'h00;
    op        = r.opcode;
    src       = 8'h00;
    res       = 8'h00;
    // only bit 0 selects the pointer, so just registers zero and one
    ptr       = rd_ram({7'h00, op[0]});
    daddr     = r.byte1;
    wr_direct = 1'b0;
    wr_ind    = 1'b0;
    wr_reg    = 1'b0;
    seq_pc    = r.pc;
    rel       = 8'h00;
    next_r.fetch_req = 1'b0;

    case (r.state)
      // pc counts every accepted byte, so it always names the next one
      MIE_FETCH_OP: begin
        next_r.fetch_req = 1'b1;
        if (prog_valid_in) begin
          next_r.opcode = prog_data_in;
          next_r.pc     = r.pc + 16'h0001;
          next_r.state  = (extra_bytes(prog_data_in) == 2'd0) ?
                          MIE_EXEC : MIE_FETCH_B1;
        end
      end
      MIE_FETCH_B1: begin
        next_r.fetch_req = 1'b1;
        if (prog_valid_in) begin
          next_r.byte1 = prog_data_in;
          next_r.pc    = r.pc + 16'h0001;
          next_r.state = (extra_bytes(r.opcode) == 2'd2) ?
                         MIE_FETCH_B2 : MIE_EXEC;
        end
      end
      MIE_FETCH_B2: begin
        next_r.fetch_req = 1'b1;
        if (prog_valid_in) begin
          next_r.byte2 = prog_data_in;
          next_r.pc    = r.pc + 16'h0001;
          next_r.state = MIE_EXEC;
        end
      end
      MIE_EXEC: begin
        next_r.state   = MIE_FETCH_OP;
        // request the next opcode now so the fetch state never idles
        next_r.fetch_req = 1'b1;
        // flag marks only the latest instruction; each execute clears it
        next_r.illegal = 1'b0;
        if (op == `MIE_OPC_MOV_A_IMM) begin
          next_r.acc = r.byte1;
        end else if (op == `MIE_OPC_MOV_A_DIR) begin
          next_r.acc = rd_direct(r.byte1, r);
        end else if (op == `MIE_OPC_MOV_DIR_A) begin
          src = r.acc;
          wr_direct = 1'b1;
        end else if (op == `MIE_OPC_MOV_DIR_IMM) begin
          src = r.byte2;
          wr_direct = 1'b1;
        end else if (op == `MIE_OPC_MOV_DIR_DIR) begin
          // source byte precedes destination in the encoding
          src = rd_direct(r.byte1, r);
          daddr = r.byte2;
          wr_direct = 1'b1;
        end else if (op[7:1] == {`MIE_OPC_MOV_RI_IMM, 3'b011}) begin
          src = r.byte1;
          wr_ind = 1'b1;
        end else if (op[7:1] == {`MIE_OPC_MOV_DIR_RI, 3'b011}) begin
          src = rd_ram(ptr);
          wr_direct = 1'b1;
        end else if (op[7:1] == {`MIE_OPC_MOV_RI_DIR, 3'b011}) begin
          src = rd_direct(r.byte1, r);
          wr_ind = 1'b1;
        end else if (op[7:1] == {`MIE_OPC_MOV_A_RI, 3'b011}) begin
          next_r.acc = rd_ram(ptr);
        end else if (op[7:1] == {`MIE_OPC_MOV_RI_A, 3'b011}) begin
          src = r.acc;
          wr_ind = 1'b1;
        end else if (op[7:4] == `MIE_OPC_MOV_RI_IMM && op[3]) begin
          src = r.byte1;
          wr_reg = 1'b1;
        end else if (op[7:4] == `MIE_OPC_MOV_DIR_RI && op[3]) begin
          src = rd_ram({5'h00, op[2:0]});
          wr_direct = 1'b1;
        end else if (op[7:4] == `MIE_OPC_MOV_RI_DIR && op[3]) begin
          src = rd_direct(r.byte1, r);
          wr_reg = 1'b1;
        end else if (op[7:4] == `MIE_OPC_MOV_A_RI && op[3]) begin
          next_r.acc = rd_ram({5'h00, op[2:0]});
        end else if (op[7:4] == `MIE_OPC_MOV_RI_A && op[3]) begin
          src = r.acc;
          wr_reg = 1'b1;
        end else if (op == `MIE_OPC_INC_A) begin
          next_r.acc = r.acc + `MIE_ONE;
        end else if (op == `MIE_OPC_DEC_A) begin
          next_r.acc = r.acc - `MIE_ONE;
        end else if (op == `MIE_OPC_INC_DIR || op == `MIE_OPC_DEC_DIR) begin
          src = rd_direct(r.byte1, r);
          src = (op[7:4] == `MIE_OPC_INC_HI) ? src + `MIE_ONE
                                              : src - `MIE_ONE;
          wr_direct = 1'b1;
        end else if ((op[7:4] == `MIE_OPC_INC_IND ||
                      op[7:4] == `MIE_OPC_DEC_IND) && op[3:1] == 3'b011) begin
          src = rd_ram(ptr);
          src = (op[7:4] == `MIE_OPC_INC_HI) ? src + `MIE_ONE
                                              : src - `MIE_ONE;
          wr_ind = 1'b1;
        end else if ((op[7:4] == `MIE_OPC_INC_HI ||
                      op[7:4] == `MIE_OPC_DEC_HI) && op[3]) begin
          src = rd_ram({5'h00, op[2:0]});
          src = (op[7:4] == `MIE_OPC_INC_HI) ? src + `MIE_ONE
                                              : src - `MIE_ONE;
          wr_reg = 1'b1;
        end else if (op[7:3] == `MIE_OPC_DECREMENT_BRANCH_NONZERO_OP_RN ||
                     op == `MIE_OPC_DECREMENT_BRANCH_NONZERO_OP_DIR) begin
          // decrement first, then test the new value; psw untouched
          if (op == `MIE_OPC_DECREMENT_BRANCH_NONZERO_OP_DIR) begin
            res = rd_direct(r.byte1, r) - `MIE_ONE;
            src = res;
            wr_direct = 1'b1;
          end else begin
            res = rd_ram({5'h00, op[2:0]}) - `MIE_ONE;
            src = res;
            wr_reg = 1'b1;
          end
          seq_pc = r.pc;
          // offset is relative to the byte after the instruction
          rel = (op == `MIE_OPC_DECREMENT_BRANCH_NONZERO_OP_DIR) ? r.byte2 : r.byte1;
          if (res != 8'h00) begin
            // count n gives n passes (a count of zero gives 256): exit only once zero is reached
            next_r.pc = seq_pc + {{8{rel[7]}}, rel};
          end
        end else begin
          // unlisted codes, incl. reg-to-reg and indirect-to-indirect
          next_r.illegal = 1'b1;
        end
        // sfrs other than the modelled ones silently drop the write
        if (wr_direct) begin
          if (daddr < `MIE_ADDR_PORT_ZERO) begin
            ram_we = 1'b1;
            ram_waddr = daddr;
            ram_wdata = src;
          end else if (daddr == `MIE_ADDR_PORT_ZERO) begin
            next_r.port_zero_latch = src;
          end else if (daddr == `MIE_ADDR_ACC) begin
            next_r.acc = src;
          end else if (daddr == `MIE_ADDR_PSW) begin
            next_r.psw = src;
          end
        end else if (wr_ind) begin
          ram_we = 1'b1;
          ram_waddr = ptr;
          ram_wdata = src;
        end else if (wr_reg) begin
          ram_we = 1'b1;
          ram_waddr = {5'h00, op[2:0]};
          ram_wdata = src;
        end
      end
      default: next_r.state = MIE_FETCH_OP;
    endcase
    if (r.state != MIE_EXEC && next_r.state == MIE_EXEC) begin
      next_r.fetch_req = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      r.state           <= MIE_FETCH_OP;
      r.pc              <= `MIE_PC_RESET;
      r.opcode          <= 8'h00;
      r.byte1           <= 8'h00;
      r.byte2           <= 8'h00;
      r.acc             <= `MIE_ACC_RESET;
      r.psw             <= `MIE_PSW_RESET;
      r.port_zero_latch <= `MIE_PORT_ZERO_RESET;
      r.illegal         <= 1'b0;
      r.fetch_req       <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ram cleared at reset so indirect reads are defined; one byte of
  // flip-flops per entry, written only when its own address is selected
  for (genvar g = 0; g < RAM_DEPTH; g++) begin : g_ram
    localparam logic [7:0] ENTRY = 8'(g);
    always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
        ram[g] <= `MIE_RAM_RESET;
      end else if (ram_we && ram_waddr == ENTRY) begin
        ram[g] <= ram_wdata;
      end
    end
  end

  assign prog_req_out        = r.fetch_req;
  assign prog_addr_out       = r.pc;
  assign acc_out             = r.acc;
  assign psw_out             = r.psw;
  assign port_zero_latch_out = r.port_zero_latch;
  assign illegal_op_out      = r.illegal;
endmodule

/* logic/mie_params.svh */
// constants for the move / increment / loop execution block
`ifndef MIE_PARAMS_SVH
`define MIE_PARAMS_SVH
`define MIE_ADDR_PORT_ZERO   8'h80
`define MIE_ADDR_ACC         8'hE0
`define MIE_ADDR_PSW         8'hD0
`define MIE_PORT_ZERO_RESET  8'hFF
`define MIE_ACC_RESET        8'h00
`define MIE_PSW_RESET        8'h00
`define MIE_PC_RESET         16'h0000
`define MIE_RAM_RESET        8'h00
`define MIE_ONE              8'h01
`define MIE_OPC_INC_A        8'h04
`define MIE_OPC_INC_DIR      8'h05
`define MIE_OPC_INC_IND      4'h0
`define MIE_OPC_DEC_A        8'h14
`define MIE_OPC_DEC_DIR      8'h15
`define MIE_OPC_DEC_IND      4'h1
`define MIE_OPC_INC_HI       4'h0
`define MIE_OPC_DEC_HI       4'h1
`define MIE_OPC_MOV_A_IMM    8'h74
`define MIE_OPC_MOV_DIR_IMM  8'h75
`define MIE_OPC_MOV_RI_IMM   4'h7
`define MIE_OPC_MOV_DIR_DIR  8'h85
`define MIE_OPC_MOV_DIR_RI   4'h8
`define MIE_OPC_MOV_RI_DIR   4'hA
`define MIE_OPC_MOV_A_RI     4'hE
`define MIE_OPC_MOV_RI_A     4'hF
`define MIE_OPC_MOV_A_DIR    8'hE5
`define MIE_OPC_MOV_DIR_A    8'hF5
`define MIE_OPC_DECREMENT_BRANCH_NONZERO_OP_DIR     8'hD5
`define MIE_OPC_DECREMENT_BRANCH_NONZERO_OP_RN      5'h1B
`endif

/* logic/mie_pkg.sv */
// types for the move / increment / loop execution block
package mie_pkg;
  typedef enum logic [1:0] {
    MIE_FETCH_OP,
    MIE_FETCH_B1,
    MIE_FETCH_B2,
    MIE_EXEC
  } mie_state_t;

  typedef struct packed {
    mie_state_t  state;
    logic [15:0] pc;
    logic [7:0]  opcode;
    logic [7:0]  byte1;
    logic [7:0]  byte2;
    logic [7:0]  acc;
    logic [7:0]  psw;
    logic [7:0]  port_zero_latch;
    logic        illegal;
    logic        fetch_req;
  } mie_regs_t;
endpackage

/* test/mie_exec_bench.sv */
// self-checking bench for the execution block
`timescale 1ns/1ps
module mie_exec_bench;
  logic        sys_clk_in, srst_in, slow, prog_valid, prog_req_out;
  logic        illegal_op_out;
  logic [7:0]  prog_data, acc_out, psw_out, port_zero_latch_out;
  logic [15:0] prog_addr_out, limit, fill;
  int          mismatches, checks_done;

  mie_exec u_mie_exec (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .prog_data_in(prog_data), .prog_valid_in(prog_valid),
    .prog_req_out(prog_req_out), .prog_addr_out(prog_addr_out),
    .acc_out(acc_out), .psw_out(psw_out),
    .port_zero_latch_out(port_zero_latch_out),
    .illegal_op_out(illegal_op_out));
  mie_prog_mem u_mie_prog_mem (.sys_clk_in(sys_clk_in),
    .prog_req_in(prog_req_out), .prog_addr_in(prog_addr_out),
    .limit_in(limit), .slow_in(slow), .prog_valid_out(prog_valid),
    .prog_data_out(prog_data));

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input string nm, input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // append code, open it to the fetcher, wait for pc to settle at the end
  task automatic go(input logic [7:0] q[$]);
    int n = 0;
    int k = 0;
    foreach (q[i]) begin
      u_mie_prog_mem.mem[fill[7:0]] = q[i];
      fill = fill + 16'h0001;
    end
    @(posedge sys_clk_in);
    limit <= fill;
    while (k < 4 && n < 400) begin
      @(negedge sys_clk_in);
      n++;
      if (prog_addr_out === fill) k++;
      else k = 0;
    end
    if (k < 4) mismatches++;
  endtask

  task automatic t_moves();
    go('{8'h74, 8'h3C, 8'hF5, 8'h80});
    chk("acc", acc_out, 8'h3C);
    chk("latch", port_zero_latch_out, 8'h3C);
    go('{8'h75, 8'h80, 8'h55, 8'h75, 8'h40, 8'hA5, 8'h85, 8'h40, 8'h41,
         8'hE5, 8'h41});
    chk("latch", port_zero_latch_out, 8'h55);
    chk("acc", acc_out, 8'hA5);
  endtask

  task automatic t_indirect();
    go('{8'h78, 8'hFF, 8'h76, 8'h5A, 8'h79, 8'h20, 8'h77, 8'hC3, 8'hE6});
    chk("acc", acc_out, 8'h5A);
    go('{8'hE7});
    chk("acc", acc_out, 8'hC3);
    go('{8'hE9, 8'hFA, 8'h74, 8'h00, 8'hEA});
    chk("acc", acc_out, 8'h20);
  endtask

  task automatic t_illegal();
    go('{8'hA5});
    chk("illegal", {7'h00, illegal_op_out}, 8'h01);
    chk("acc", acc_out, 8'h20);
    go('{8'h04});
    chk("illegal", {7'h00, illegal_op_out}, 8'h00);
    chk("acc", acc_out, 8'h21);
  endtask

  task automatic t_incdec();
    go('{8'h75, 8'hD0, 8'hC4, 8'h74, 8'hFF, 8'h04});
    chk("acc", acc_out, 8'h00);
    chk("psw", psw_out, 8'hC4);
    go('{8'h14});
    chk("acc", acc_out, 8'hFF);
    chk("psw", psw_out, 8'hC4);
    go('{8'h75, 8'h30, 8'hFF, 8'h05, 8'h30, 8'hE5, 8'h30});
    chk("acc", acc_out, 8'h00);
    go('{8'h79, 8'h00, 8'h19, 8'hE9});
    chk("acc", acc_out, 8'hFF);
    go('{8'h78, 8'h50, 8'h76, 8'h07, 8'h06, 8'hE6});
    chk("acc", acc_out, 8'h08);
  endtask

  task automatic t_loop();
    @(posedge sys_clk_in);
    slow <= 1'b1;
    go('{8'h75, 8'hD0, 8'h81, 8'h78, 8'h08, 8'h74, 8'h00, 8'h04, 8'hD8,
         8'hFD});
    chk("acc", acc_out, 8'h08);
    chk("psw", psw_out, 8'h81);
    go('{8'hE8});
    chk("acc", acc_out, 8'h00);
    go('{8'h75, 8'h31, 8'h03, 8'h74, 8'h00, 8'h04, 8'hD5, 8'h31, 8'hFC});
    chk("acc", acc_out, 8'h03);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge sys_clk_in);
    mismatches++;
    close_out();
  end

  initial begin
    srst_in = 1'b1;
    slow = 1'b0;
    limit = 16'h0000;
    fill = 16'h0000;
    repeat (6) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    t_moves();
    t_indirect();
    t_illegal();
    t_incdec();
    t_loop();
    close_out();
  end
endmodule

/* test/mie_exec_props.sv */
// port-level assertion checker for the execution block
`timescale 1ns/1ps
`include "mie_params.svh"
module mie_exec_props #(
  parameter int RAM_DEPTH = 256
) (
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic [7:0]  prog_data_in,
  input wire logic        prog_valid_in,
  input wire logic        prog_req_out,
  input wire logic [15:0] prog_addr_out,
  input wire logic [7:0]  acc_out,
  input wire logic [7:0]  psw_out,
  input wire logic [7:0]  port_zero_latch_out,
  input wire logic        illegal_op_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  property p_reset_vals;
    disable iff (1'b0)
    srst_in |=> acc_out == `MIE_ACC_RESET && psw_out == `MIE_PSW_RESET
      && port_zero_latch_out == `MIE_PORT_ZERO_RESET && !illegal_op_out
      && prog_addr_out == `MIE_PC_RESET && !prog_req_out;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");

  property p_req_after_reset;
    $fell(srst_in) |=> prog_req_out;
  endproperty
  a_req_after_reset: assert property (p_req_after_reset) else $error("no fetch");

  property p_one_dest;
    $changed(acc_out) |-> $stable(port_zero_latch_out) && $stable(psw_out);
  endproperty
  a_one_dest: assert property (p_one_dest) else $error("two targets");

  // results land in the execute slot, when no byte can be taken
  property p_write_no_fetch;
    ($changed(acc_out) || $changed(port_zero_latch_out) || $changed(psw_out))
      |-> !$past(prog_req_out);
  endproperty
  a_write_no_fetch: assert property (p_write_no_fetch) else $error("early");

  property p_illegal_no_write;
    $rose(illegal_op_out) |-> $stable(acc_out) && $stable(psw_out)
      && $stable(port_zero_latch_out);
  endproperty
  a_illegal_no_write: assert property (p_illegal_no_write) else $error("wr");

  property p_acc_gap;
    $changed(acc_out) |=> $stable(acc_out);
  endproperty
  a_acc_gap: assert property (p_acc_gap) else $error("acc twice");

  property p_latch_gap;
    $changed(port_zero_latch_out) |=> $stable(port_zero_latch_out);
  endproperty
  a_latch_gap: assert property (p_latch_gap) else $error("latch twice");

  sequence s_starved;
    !prog_valid_in [*3];
  endsequence
  property p_idle_stable;
    s_starved ##1 1'b1 |-> $stable(acc_out) && $stable(psw_out);
  endproperty
  a_idle_stable: assert property (p_idle_stable) else $error("drift");

  c_illegal: cover property ($rose(illegal_op_out));
  c_latch: cover property ($changed(port_zero_latch_out));
  c_loop: cover property (acc_out == 8'h08);
endmodule

bind mie_exec mie_exec_props #(.RAM_DEPTH(RAM_DEPTH)) u_mie_exec_props (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .prog_data_in(prog_data_in),
  .prog_valid_in(prog_valid_in), .prog_req_out(prog_req_out),
  .prog_addr_out(prog_addr_out), .acc_out(acc_out), .psw_out(psw_out),
  .port_zero_latch_out(port_zero_latch_out),
  .illegal_op_out(illegal_op_out));

/* test/mie_prog_mem.sv */
// program memory model answering the execution block's fetches
`timescale 1ns/1ps
module mie_prog_mem (
  input  wire logic        sys_clk_in,
  input  wire logic        prog_req_in,
  input  wire logic [15:0] prog_addr_in,
  input  wire logic [15:0] limit_in,
  input  wire logic        slow_in,
  output logic             prog_valid_out,
  output logic [7:0]       prog_data_out
);
  logic [7:0] mem [0:255];
  logic       skip = 1'b0;
  logic [7:0] noise = 8'h00;
  always @(posedge sys_clk_in) begin
    skip <= slow_in & ~skip;
    noise <= noise + 8'h3B;
  end
  // nothing past the fill mark; idle data moves so stale bytes never match
  assign prog_valid_out = prog_req_in && prog_addr_in < limit_in && !skip;
  assign prog_data_out = prog_valid_out ? mem[prog_addr_in[7:0]] : noise;
endmodule
